// >>> camp_defines.svh
// Constants for the counter array mode and PWM configuration block
// Function
// - Mode register holds watchdog lock bit: 0 unlocked, 1 locks the enable.
// - Mode register bit 4 always reads zero; writes to it are ignored.
// - Timebase 000 sysclk/12, 001 sysclk/4, 100 sysclk; 110 and 111 reserved.
// - Timebase 010 advances counter once per timer 0 overflow.
// - Timebase 011 counts falling count-input edges; source at most sysclk/4.
// - Timebase 101 uses external clock divided by eight, synchronised.
// - Overflow interrupt enable gates counter overflow flag onto interrupt.
// - While watchdog enabled, writes to other mode register bits are ignored.
// - Reload select steers capture/compare addresses to reload registers.
// - Reload registers act only in 9-15 bit and 16-bit PWM modes.
// - PWM config bit 6 is cycle overflow interrupt enable, resets zero.
// - Watchdog enable dedicates module 2 to watchdog; zero disables it.
// - Once lock is set the watchdog stays enabled until reset.
// - Overflow flag sets on 16-bit wrap to zero; only software clears.
// - Cycle overflow flag raises interrupt only when its enable is one.
`ifndef CAMP_DEFINES_SVH
`define CAMP_DEFINES_SVH
// Register addresses
`define CAMP_ADDR_CTRL 8'hD8
`define CAMP_ADDR_MODE 8'hD9
`define CAMP_ADDR_PWM 8'hF7
`define CAMP_ADDR_CNT_LO 8'hF9
`define CAMP_ADDR_CNT_HI 8'hFA
`define CAMP_ADDR_CC0_LO 8'hE9
`define CAMP_ADDR_CC0_HI 8'hEA
`define CAMP_ADDR_CC1_LO 8'hEB
`define CAMP_ADDR_CC1_HI 8'hEC
`define CAMP_ADDR_CC2_LO 8'hED
`define CAMP_ADDR_CC2_HI 8'hEE
// Field positions
`define CAMP_CTRL_CF 7
`define CAMP_CTRL_RUN 6
`define CAMP_MODE_IDLE 7
`define CAMP_MODE_WATCHDOG_ENABLE 6
`define CAMP_MODE_WATCHDOG_LOCK 5
`define CAMP_MODE_ECF 0
`define CAMP_PWM_RELOAD_REG_SELECT 7
`define CAMP_PWM_CYCLE_OVERFLOW_IRQ_ENABLE 6
`define CAMP_PWM_CYCLE_OVERFLOW_FLAG 5
`define CAMP_PWM_WIDE_PWM_RELOAD_ENABLE 3
// Reset values
`define CAMP_MODE_RESET 8'h40
`define CAMP_PWM_RESET 8'h00
// Timebase codes
`define CAMP_TB_DIV12 3'h0
`define CAMP_TB_DIV4 3'h1
`define CAMP_TB_T0 3'h2
`define CAMP_TB_ECI 3'h3
`define CAMP_TB_SYS 3'h4
`define CAMP_TB_EXT8 3'h5
// Timing counts
`define CAMP_DIV12_LAST 4'hB
`define CAMP_DIV4_LAST 2'h3
`define CAMP_EXT8_LAST 3'h7
`endif

// >>> camp_pkg.sv
// Types shared by the counter array mode block
package camp_pkg;
  typedef logic [7:0] camp_byte_t;
  typedef logic [2:0] camp_tb_t;
  typedef logic [3:0] camp_idx_t;
endpackage : camp_pkg

// >>> camp_ccmem_if.sv
// Carrier between the register decoder and the compare/reload store
`timescale 1ns/1ps
interface camp_ccmem_if;
  logic [3:0] idx;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output idx, output wr, output wdata, input rdata);
  modport mem (input idx, input wr, input wdata, output rdata);
endinterface : camp_ccmem_if

// >>> camp_ccmem.sv
// Byte store for capture/compare and auto-reload registers
`timescale 1ns/1ps
module camp_ccmem
  import camp_pkg::*;
#(
  parameter int DEPTH = 16
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Decoder side
  camp_ccmem_if.mem port
);

  logic [7:0] store [DEPTH];

  ////////////////////////////////////////////////////////////////////////
  // Write port; contents left unreset as in a plain RAM
  always_ff @(posedge sys_clk)
  begin
    if (port.wr)
    begin
      store[port.idx] <= port.wdata;
    end
  end

  // Registered read, one cycle after the index is presented
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      port.rdata <= 8'h00;
    end
    else
    begin
      port.rdata <= store[port.idx];
    end
  end

endmodule : camp_ccmem

// >>> camp_top.sv
// Counter array timebase, mode, watchdog lock and PWM configuration
`timescale 1ns/1ps
`include "camp_defines.svh"
module camp_top
  import camp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Special-function register port
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // Timebase sources and processor idle status
  input wire logic timer0_overflow,
  input wire logic ext_count_input,
  input wire logic ext_clk,
  input wire logic cpu_idle,
  // Module status from the channel logic
  input wire logic [2:0] pwm_mode_active,
  // Outputs
  output logic irq,
  output logic watchdog_enable,
  output logic [2:0] reload_apply,
  output logic [15:0] count
);

  camp_byte_t mode_reg;
  camp_byte_t pwm_reg, reg_rdata, cc_rdata;
  logic cf;
  logic run;
  logic [3:0] div12;
  logic [1:0] div4;
  logic [2:0] ext8;
  logic eci_s1, eci_s2, eci_prev;
  logic xck_s1, xck_s2, xck_prev;
  logic eci_fall, xck_rise, tick, step;
  logic rd_cc;
  camp_idx_t cc_idx, cc_dec;
  camp_tb_t tsel;
  camp_ccmem_if ccm ();

  assign tsel = mode_reg[3:1];
  // Enable bit hands module 2 to the watchdog
  assign watchdog_enable = mode_reg[`CAMP_MODE_WATCHDOG_ENABLE];

  ////////////////////////////////////////////////////////////////////////
  // Address decode for the compare/reload byte store
  function automatic logic [3:0] cc_decode(input logic [7:0] a);
    case (a)
      `CAMP_ADDR_CC0_LO: cc_decode = {1'b1, 2'h0, 1'b0};
      `CAMP_ADDR_CC0_HI: cc_decode = {1'b1, 2'h0, 1'b1};
      `CAMP_ADDR_CC1_LO: cc_decode = {1'b1, 2'h1, 1'b0};
      `CAMP_ADDR_CC1_HI: cc_decode = {1'b1, 2'h1, 1'b1};
      `CAMP_ADDR_CC2_LO: cc_decode = {1'b1, 2'h2, 1'b0};
      `CAMP_ADDR_CC2_HI: cc_decode = {1'b1, 2'h2, 1'b1};
      default: cc_decode = 4'h0;
    endcase
  endfunction : cc_decode

  // True when the low n bits (n = 8 + select) are all ones
  function automatic logic low_all_ones(input logic [15:0] c,
                                        input logic [2:0] sel);
    logic [15:0] mask;
    mask = 16'hFFFF >> (4'h8 - {1'b0, sel});
    low_all_ones = ((c & mask) == mask);
  endfunction : low_all_ones

  ////////////////////////////////////////////////////////////////////////
  // Counter mode register
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      mode_reg <= `CAMP_MODE_RESET;
    end
    else if (sfr_wr && sfr_addr == `CAMP_ADDR_MODE)
    begin
      if (mode_reg[`CAMP_MODE_WATCHDOG_ENABLE])
      begin
        if (!mode_reg[`CAMP_MODE_WATCHDOG_LOCK])
        begin
          mode_reg[`CAMP_MODE_WATCHDOG_ENABLE] <= sfr_wdata[`CAMP_MODE_WATCHDOG_ENABLE];
        end
      end
      else
      begin
        mode_reg <= sfr_wdata & 8'hEF;
        if (sfr_wdata[`CAMP_MODE_WATCHDOG_LOCK])
        begin
          mode_reg[`CAMP_MODE_WATCHDOG_ENABLE] <= 1'b1;
        end
      end
    end
  end

  // PWM configuration; cycle overflow set by hardware wins over clear
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      pwm_reg <= `CAMP_PWM_RESET;
    end
    else
    begin
      if (sfr_wr && sfr_addr == `CAMP_ADDR_PWM)
      begin
        pwm_reg <= sfr_wdata & 8'hEF;
      end
      if (step && low_all_ones(count, pwm_reg[2:0]))
      begin
        pwm_reg[`CAMP_PWM_CYCLE_OVERFLOW_FLAG] <= 1'b1;
      end
    end
  end

  // Control register: run bit and overflow flag
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      run <= 1'b0;
      cf <= 1'b0;
    end
    else
    begin
      if (sfr_wr && sfr_addr == `CAMP_ADDR_CTRL)
      begin
        run <= sfr_wdata[`CAMP_CTRL_RUN];
        cf <= sfr_wdata[`CAMP_CTRL_CF];
      end
      // Wrap sets flag, beats a clear
      if (step && count == 16'hFFFF)
      begin
        cf <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      eci_s1 <= 1'b1;
      eci_s2 <= 1'b1;
      eci_prev <= 1'b1;
      xck_s1 <= 1'b0;
      xck_s2 <= 1'b0;
      xck_prev <= 1'b0;
    end
    else
    begin
      eci_s1 <= ext_count_input;
      eci_s2 <= eci_s1;
      eci_prev <= eci_s2;
      xck_s1 <= ext_clk;
      xck_s2 <= xck_s1;
      xck_prev <= xck_s2;
    end
  end

  assign eci_fall = eci_prev && !eci_s2;
  assign xck_rise = xck_s2 && !xck_prev;

  // Free-running prescalers so a code change picks up at once
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      div12 <= 4'h0;
      div4 <= 2'h0;
    end
    else
    begin
      div12 <= (div12 == `CAMP_DIV12_LAST) ? 4'h0 : div12 + 4'h1;
      div4 <= div4 + 2'h1;
    end
  end

  // Divide synchronised external clock by eight
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      ext8 <= 3'h0;
    end
    else if (xck_rise)
    begin
      ext8 <= ext8 + 3'h1;
    end
  end

  always_comb
  begin
    case (tsel)
      `CAMP_TB_DIV12: tick = (div12 == `CAMP_DIV12_LAST);
      `CAMP_TB_DIV4: tick = (div4 == `CAMP_DIV4_LAST);
      `CAMP_TB_T0: tick = timer0_overflow;
      `CAMP_TB_ECI: tick = eci_fall;
      `CAMP_TB_SYS: tick = 1'b1;
      `CAMP_TB_EXT8: tick = xck_rise && (ext8 == `CAMP_EXT8_LAST);
      default: tick = 1'b0;
    endcase
  end

  // Idle control bit suspends counting while the processor idles
  assign step = tick && run && !(mode_reg[`CAMP_MODE_IDLE] && cpu_idle);

  // Count one per strobe; writable while stopped
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      count <= 16'h0000;
    end
    else if (sfr_wr && !run && sfr_addr == `CAMP_ADDR_CNT_LO)
    begin
      count[7:0] <= sfr_wdata;
    end
    else if (sfr_wr && !run && sfr_addr == `CAMP_ADDR_CNT_HI)
    begin
      count[15:8] <= sfr_wdata;
    end
    else if (step)
    begin
      count <= count + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Overflow interrupt gating
  assign irq = (cf && mode_reg[`CAMP_MODE_ECF])
    || (pwm_reg[`CAMP_PWM_CYCLE_OVERFLOW_FLAG] && pwm_reg[`CAMP_PWM_CYCLE_OVERFLOW_IRQ_ENABLE]);

  // Reload pulses only for PWM-mode channels with reload on
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      reload_apply <= 3'h0;
    end
    else if (step && count == 16'hFFFF && pwm_reg[`CAMP_PWM_WIDE_PWM_RELOAD_ENABLE])
    begin
      reload_apply <= pwm_mode_active;
    end
    else
    begin
      reload_apply <= 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reload select picks the bank
  assign cc_dec = cc_decode(sfr_addr);
  assign cc_idx = {pwm_reg[`CAMP_PWM_RELOAD_REG_SELECT], cc_dec[2:0]};
  assign ccm.idx = cc_idx;
  assign ccm.wr = sfr_wr && cc_dec[3];
  assign ccm.wdata = sfr_wdata;

  camp_ccmem #(.DEPTH(16)) u_ccmem (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .port(ccm.mem)
  );

  // Register read data, held one cycle after the read strobe
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      rd_cc <= 1'b0;
      reg_rdata <= 8'h00;
    end
    else
    begin
      rd_cc <= sfr_rd && cc_dec[3];
      reg_rdata <= 8'h00;
      if (sfr_rd)
      begin
        case (sfr_addr)
          `CAMP_ADDR_CTRL: reg_rdata <= {cf, run, 6'h00};
          `CAMP_ADDR_MODE: reg_rdata <= mode_reg;
          `CAMP_ADDR_PWM: reg_rdata <= pwm_reg;
          `CAMP_ADDR_CNT_LO: reg_rdata <= count[7:0];
          `CAMP_ADDR_CNT_HI: reg_rdata <= count[15:8];
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Store answers in the same cycle as the register bytes
  assign cc_rdata = rd_cc ? ccm.rdata : 8'h00;
  assign sfr_rdata = reg_rdata | cc_rdata;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_lock_holds_enable: assert property (mode_reg[`CAMP_MODE_WATCHDOG_LOCK]
    |-> watchdog_enable) else $error("lock set but watchdog off");
  a_mode_frozen_watchdog_enable: assert property ((sfr_wr && watchdog_enable
    && sfr_addr == `CAMP_ADDR_MODE) |=> mode_reg[5:0] == $past(mode_reg[5:0])
    && mode_reg[7] == $past(mode_reg[7])) else $error("mode bits changed");
  a_mode_bit4_zero: assert property ((sfr_rd && sfr_addr == `CAMP_ADDR_MODE)
    |=> !sfr_rdata[4]) else $error("mode bit 4 read as one");
  a_wrap_sets_cf: assert property ((step && count == 16'hFFFF)
    |=> cf && count == 16'h0000) else $error("wrap without flag");
  a_irq_masked: assert property ((!mode_reg[0] && !pwm_reg[6]) |-> !irq)
    else $error("irq while both enables off");
  a_cycle_overflow_flag_irq: assert property ((step && low_all_ones(count, pwm_reg[2:0])
    && pwm_reg[6]) |=> irq) else $error("cycle overflow not requested");
  a_reserved_quiet: assert property (tsel[2:1] == 2'b11 |-> !tick)
    else $error("strobe on reserved timebase");
  a_eci_strobe: assert property ((tsel == `CAMP_TB_ECI && $fell(eci_s2))
    |-> tick) else $error("count input edge missed");
  a_ext8_spacing: assert property ((tsel == `CAMP_TB_EXT8 && tick
    && $stable(tsel)) |=> !tick [*7]) else $error("external strobe too fast");
  a_div12_spacing: assert property ((tsel == `CAMP_TB_DIV12 && tick)
    |=> (tsel != `CAMP_TB_DIV12 || !tick) [*8])
    else $error("divide by twelve too fast");

endmodule : camp_top

// >>> tb_top.sv
// Self-checking bench for the counter array mode and PWM config block
`timescale 1ns/1ps
`include "camp_defines.svh"
module tb_top;
  import camp_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic timer0_overflow = 1'b0;
  logic ext_count_input = 1'b1;
  logic ext_clk = 1'b0;
  logic cpu_idle = 1'b0;
  logic [2:0] pwm_mode_active = 3'h0;
  logic irq;
  logic watchdog_enable;
  logic [2:0] reload_apply;
  logic [15:0] count;
  logic [2:0] seen = 3'h0;
  logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h4, 3'h6, 3'h7};
  logic [7:0] d;
  logic [7:0] ccv [12];
  int n_mismatch = 0;
  int num_checks = 0;
  int seed = 32'hf2cc;
  int n;
  int k;

  //////////////////////////////////////////////////////////////////////////
  // Clock, design and reload pulse collector
  always #25 sys_clk = ~sys_clk;

  camp_top i_camp_top (.sys_clk(sys_clk), .resetn(resetn),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .timer0_overflow(timer0_overflow), .ext_count_input(ext_count_input),
    .ext_clk(ext_clk), .cpu_idle(cpu_idle),
    .pwm_mode_active(pwm_mode_active), .irq(irq),
    .watchdog_enable(watchdog_enable), .reload_apply(reload_apply),
    .count(count));

  // Pulses last one cycle, so keep a sticky record of them
  always @(posedge sys_clk)
    seen <= seen | reload_apply;

  //////////////////////////////////////////////////////////////////////////
  // Verdict, compares and bus tasks
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  task chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t byte got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task chk_rng(input logic [15:0] got, input int lo, input int hi);
    num_checks++;
    if ($isunknown(got) || got < lo || got > hi)
    begin
      n_mismatch++;
      $display("[ERR] %0t count %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_rng

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wdata <= v;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
    // Let the written state settle before anyone looks at it
    #1;
  endtask : wr

  // Read data is registered, so it is looked at just after the next edge
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    #1 v = sfr_rdata;
  endtask : rd

  // Counter is loaded while stopped, since writes are ignored when running
  task start(input logic [2:0] code, input logic [7:0] lo, hi);
    wr(`CAMP_ADDR_MODE, {4'h0, code, 1'b0});
    wr(`CAMP_ADDR_CNT_LO, lo);
    wr(`CAMP_ADDR_CNT_HI, hi);
    wr(`CAMP_ADDR_CTRL, 8'h40);
  endtask : start

  task stop;
    wr(`CAMP_ADDR_CTRL, 8'h00);
    repeat (2) @(posedge sys_clk);
  endtask : stop

  function int steps(input logic [2:0] code, input int cyc);
    case (code)
      3'h0: return cyc / 12;
      3'h1: return cyc / 4;
      3'h4: return cyc;
      default: return 0;
    endcase
  endfunction : steps

  //////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    n_mismatch++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(`CAMP_ADDR_PWM, d);
    chk8(d, 8'h00);
    wr(`CAMP_ADDR_MODE, 8'h4F);
    rd(`CAMP_ADDR_MODE, d);
    chk8(d, 8'h40);
    wr(`CAMP_ADDR_MODE, 8'h00);
    chk8({7'h0, watchdog_enable}, 8'h00);
    wr(`CAMP_ADDR_MODE, 8'h1F);
    rd(`CAMP_ADDR_MODE, d);
    chk8(d, 8'h0F);
    // Divided, direct and reserved timebases over random run lengths
    foreach (codes[i])
    begin
      n = 48 + 12 * ($unsigned($random(seed)) % 3);
      start(codes[i], 8'h00, 8'h00);
      repeat (n) @(posedge sys_clk);
      stop();
      chk_rng(count, steps(codes[i], n),
              steps(codes[i], n + 3) + (codes[i] < 3'h2));
    end
    // Timer 0 overflow pulses with random gaps
    k = 3 + $unsigned($random(seed)) % 5;
    start(3'h2, 8'h00, 8'h00);
    repeat (k)
    begin
      @(posedge sys_clk);
      timer0_overflow <= 1'b1;
      @(posedge sys_clk);
      timer0_overflow <= 1'b0;
      repeat (1 + $unsigned($random(seed)) % 4) @(posedge sys_clk);
    end
    stop();
    chk_rng(count, k, k);
    // Count-input falls, each level held at least four cycles
    k = 3 + $unsigned($random(seed)) % 6;
    start(3'h3, 8'h00, 8'h00);
    repeat (k)
    begin
      @(posedge sys_clk);
      ext_count_input <= 1'b0;
      repeat (4 + $unsigned($random(seed)) % 3) @(posedge sys_clk);
      ext_count_input <= 1'b1;
      repeat (4) @(posedge sys_clk);
    end
    repeat (6) @(posedge sys_clk);
    stop();
    chk_rng(count, k, k);
    // External clock, 24 rises give three steps
    start(3'h5, 8'h00, 8'h00);
    repeat (48)
    begin
      repeat (3) @(posedge sys_clk);
      ext_clk <= ~ext_clk;
    end
    repeat (8) @(posedge sys_clk);
    stop();
    chk_rng(count, 3, 3);
    // Wrap from all ones, then park on a reserved code to keep the flag
    start(3'h4, 8'hFE, 8'hFF);
    wr(`CAMP_ADDR_MODE, 8'h0C);
    rd(`CAMP_ADDR_CTRL, d);
    chk8(d & 8'h80, 8'h80);
    chk8({7'h0, irq}, 8'h00);
    wr(`CAMP_ADDR_MODE, 8'h0D);
    chk8({7'h0, irq}, 8'h01);
    wr(`CAMP_ADDR_CTRL, 8'h00);
    chk8({7'h0, irq}, 8'h00);
    wr(`CAMP_ADDR_PWM, 8'h50);
    rd(`CAMP_ADDR_PWM, d);
    chk8(d, 8'h40);
    wr(`CAMP_ADDR_PWM, 8'h60);
    chk8({7'h0, irq}, 8'h01);
    wr(`CAMP_ADDR_PWM, 8'h20);
    chk8({7'h0, irq}, 8'h00);
    // Both banks at the shared compare addresses keep their own bytes
    for (int b = 0; b < 2; b++)
    begin
      wr(`CAMP_ADDR_PWM, {b[0], 7'h00});
      for (int a = 0; a < 6; a++)
      begin
        ccv[b * 6 + a] = 8'($random(seed));
        wr(`CAMP_ADDR_CC0_LO + a[7:0], ccv[b * 6 + a]);
      end
    end
    for (int b = 0; b < 2; b++)
    begin
      wr(`CAMP_ADDR_PWM, {b[0], 7'h00});
      for (int a = 0; a < 6; a++)
      begin
        rd(`CAMP_ADDR_CC0_LO + a[7:0], d);
        chk8(d, ccv[b * 6 + a]);
      end
    end
    // Reload pulses only with the enable set and channels in PWM mode
    @(posedge sys_clk);
    pwm_mode_active <= 3'h1 | 3'($random(seed));
    for (int e = 0; e < 2; e++)
    begin
      // Second pass also enables the cycle overflow request
      wr(`CAMP_ADDR_PWM, {1'b0, e[0], 2'h0, e[0], 3'h0});
      start(3'h4, 8'hFD, 8'hFF);
      repeat (8) @(posedge sys_clk);
      stop();
      chk8({5'h0, seen}, e ? {5'h0, pwm_mode_active} : 8'h00);
    end
    chk8({7'h0, irq}, 8'h01);
    // Lock forces the enable on and holds it until reset
    wr(`CAMP_ADDR_MODE, 8'h20);
    chk8({7'h0, watchdog_enable}, 8'h01);
    wr(`CAMP_ADDR_MODE, 8'h00);
    rd(`CAMP_ADDR_MODE, d);
    chk8(d, 8'h60);
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(`CAMP_ADDR_MODE, d);
    chk8(d, 8'h40);
    report_and_stop();
  end
endmodule : tb_top
